// ---- core/pmc_cmd_decoder.sv ----
// Serial slave command decoder with extended registers and alert flags
// Summary of operation
// - Address with write, ack, stop is presence probe
// - First byte MSB zero is acked command byte
// - First byte MSB one starts extended write
// - Continuous voltage; early read acked, returns zeros
// - Single voltage conversion; reads nacked until done
// - Continuous current; early read acked, returns zeros
// - Single current conversion; reads nacked until done
// - Bit four picks voltage divider output
// - Bit six makes reads return status byte
// - Extended write: select byte, data byte, acks
// - Select low bits pick enable, threshold, control
// - Single current hit over threshold alerts
// - Four consecutive current hits alert
// - Hot swap fault alert enable resets set
// - Off by pin or software alerts
// - Clear bit wipes flags then self-clears
// - Flags may set again right after clear
// - Address is 100 plus two pin pairs
// - Control bit zero forces hot swap off
// - Threshold against top current bits, resets full
`timescale 1ns/1ps
`default_nettype none

module pmc_cmd_decoder (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic [1:0]            address_pin_high,
    input  wire logic [1:0]            address_pin_low,
    input  wire logic                  on_pin,
    input  wire logic                  hot_swap_overcurrent,
    input  wire logic                  hot_swap_fault_event,
    input  wire pmc_pkg::pmc_adc_res_t adc_res,
    output pmc_pkg::pmc_adc_req_t      adc_req,
    output logic                       software_off,
    output logic                       off_status,
    output logic                       alert_out
);
    import pmc_pkg::*;

    pmc_state_t s;
    pmc_state_t n;
    logic [6:0] sync_q;
    logic       scl_s;
    logic       sda_s;
    logic       on_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [6:0] own_addr;
    logic       mode_v;
    logic       mode_i;
    logic       i_over;
    logic       off_now;
    logic [7:0] status_byte;
    logic [7:0] rd_data;
    logic       clr;
    logic       adc_event;
    logic       hs_event;
    logic       off_event;
    logic       wr_done;
    logic       cmd_wr;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    pmc_sync #(
        .W    (7),
        .INIT (7'h7f)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .din     ({scl_in, sda_in, on_pin, address_pin_high, address_pin_low}),
        .dout    (sync_q)
    );

    // Line events seen on the synchronised bus lines
    assign scl_s      = sync_q[6];
    assign sda_s      = sync_q[5];
    assign on_s       = sync_q[4];
    assign scl_rise   = scl_s & ~s.scl_q;
    assign scl_fall   = ~scl_s & s.scl_q;
    assign start_cond = scl_s & s.scl_q & s.sda_q & ~sda_s;
    assign stop_cond  = scl_s & s.scl_q & ~s.sda_q & sda_s;
    assign own_addr   = {ADDR_BASE, sync_q[3:2], sync_q[1:0]};

    // Readback selection and status byte
    assign mode_v      = s.cmd[CMD_VOLTAGE_CONTINUOUS] | s.cmd[CMD_V_ONCE];
    assign mode_i      = s.cmd[CMD_CURRENT_CONTINUOUS] | s.cmd[CMD_I_ONCE];
    assign off_now     = ~on_s | s.ctrl[CTRL_SOFTWARE_OFF];
    assign status_byte = {2'h0, s.off_alert, off_now, s.hs_flag, hot_swap_overcurrent,
                          s.adc_alert, (s.over_cnt >= OC_STATUS_RUN)};

    // Byte for the current read index; zeros fill past the format end
    assign rd_data = s.cmd[CMD_STATUS] ? ((s.byte_idx == 2'h0) ? status_byte : 8'h00)
        : (mode_v & mode_i) ? ((s.byte_idx == 2'h0) ? s.v_code[11:4]
            : (s.byte_idx == 2'h1) ? s.i_code[11:4]
            : (s.byte_idx == 2'h2) ? {s.v_code[3:0], s.i_code[3:0]} : 8'h00)
        : mode_v ? ((s.byte_idx == 2'h0) ? s.v_code[11:4]
            : (s.byte_idx == 2'h1) ? {s.v_code[3:0], 4'h0} : 8'h00)
        : mode_i ? ((s.byte_idx == 2'h0) ? s.i_code[11:4]
            : (s.byte_idx == 2'h1) ? {s.i_code[3:0], 4'h0} : 8'h00)
        : 8'h00;

    // Alert sources, each gated by its enable
    assign clr       = s.alert_en[EN_CLEAR];
    assign i_over    = adc_res.current_code[11:4] > s.thresh;
    assign adc_event = adc_res.current_done & i_over & (s.alert_en[EN_SINGLE_OC]
                     | (s.alert_en[EN_QUAD_OC] & (s.over_cnt == OC_PRIOR_RUN)));
    assign hs_event  = hot_swap_fault_event & s.alert_en[EN_HS_FAULT];
    assign off_event = s.alert_en[EN_OFF] & ((s.on_q & ~on_s)
                     | (s.ctrl[CTRL_SOFTWARE_OFF] & ~s.software_off_q));

    // Byte completion in write phase, shared with the checks below
    assign wr_done = (s.fsm == BUS_WR) & scl_fall & (s.cnt == BITS_PER_BYTE)
                   & ~start_cond & ~stop_cond;
    assign cmd_wr  = wr_done & (s.byte_idx == 2'h0) & ~s.rx[EXT_FLAG_BIT];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n         = s;
        n.v_start = 1'b0;
        n.i_start = 1'b0;
        n.scl_q   = scl_s;
        n.sda_q   = sda_s;
        n.on_q    = on_s;
        n.software_off_q = s.ctrl[CTRL_SOFTWARE_OFF];
        n.alert_en[EN_CLEAR] = 1'b0;
        // Conversion results; a finished single conversion releases reads
        if (adc_res.voltage_done) begin
            n.v_code    = adc_res.voltage_code;
            n.v_pending = 1'b0;
        end
        if (adc_res.current_done) begin
            n.i_code    = adc_res.current_code;
            n.i_pending = 1'b0;
            if (!i_over) begin
                n.over_cnt = 3'h0;
            end else if (s.over_cnt != 3'h7) begin
                n.over_cnt = 3'(s.over_cnt + 3'h1);
            end
        end
        // Sticky flags: a new event beats a clear in the same cycle
        n.adc_alert = (s.adc_alert & ~clr) | adc_event;
        n.hs_flag   = (s.hs_flag & ~clr) | hs_event;
        n.off_alert = (s.off_alert & ~clr) | off_event;
        // Bus sequencing; stop and start override any phase
        if (stop_cond) begin
            n.fsm    = BUS_IDLE;
            n.sda_oe = 1'b0;
        end else if (start_cond) begin
            n.fsm       = BUS_ADDR;
            n.cnt       = 4'h0;
            n.byte_idx  = 2'h0;
            n.rw        = 1'b0;
            n.ext_write = 1'b0;
            n.sda_oe    = 1'b0;
        end else begin
            case (s.fsm)
                BUS_ADDR, BUS_WR: begin
                    if (scl_rise) begin
                        n.rx  = {s.rx[6:0], sda_s};
                        n.cnt = 4'(s.cnt + 4'h1);
                    end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                        n.cnt = 4'h0;
                        if (s.fsm == BUS_ADDR) begin
                            // Reads wait out a single conversion by not answering
                            if (s.rx[7:1] == own_addr && !(s.rx[0] && (s.v_pending || s.i_pending))) begin
                                n.fsm    = BUS_ADDR_ACK;
                                n.sda_oe = 1'b1;
                                n.rw     = s.rx[0];
                            end else begin
                                n.fsm = BUS_IDLE;
                            end
                        end else begin
                            n.fsm      = BUS_WR_ACK;
                            n.sda_oe   = 1'b1;
                            n.byte_idx = (s.byte_idx == 2'h3) ? s.byte_idx : 2'(s.byte_idx + 2'h1);
                            if (s.byte_idx == 2'h0 && s.rx[EXT_FLAG_BIT]) begin
                                n.ext_write = 1'b1;
                                n.ext_sel   = s.rx[1:0];
                            end else if (s.byte_idx == 2'h0) begin
                                // Bit five is dropped so it never reaches the core
                                n.cmd = {s.rx[6], 1'b0, s.rx[4:0]};
                                n.v_start   = s.rx[CMD_V_ONCE];
                                n.v_pending = s.rx[CMD_V_ONCE];
                                n.i_start   = s.rx[CMD_I_ONCE];
                                n.i_pending = s.rx[CMD_I_ONCE];
                                if (s.rx[CMD_VOLTAGE_CONTINUOUS] || s.rx[CMD_V_ONCE]) begin
                                    n.v_code = 12'h000;
                                end
                                if (s.rx[CMD_CURRENT_CONTINUOUS] || s.rx[CMD_I_ONCE]) begin
                                    n.i_code = 12'h000;
                                end
                            end else if (s.byte_idx == 2'h1 && s.ext_write) begin
                                case (s.ext_sel)
                                    SEL_ALERT_ENABLE:     n.alert_en = s.rx & ALERT_ENABLE_MASK;
                                    SEL_ALERT_THRESHOLD:  n.thresh   = s.rx;
                                    SEL_HOT_SWAP_CONTROL: n.ctrl     = s.rx & HOT_SWAP_CONTROL_MASK;
                                    default:              n.ctrl     = s.ctrl;
                                endcase
                            end
                        end
                    end
                end
                BUS_ADDR_ACK, BUS_WR_ACK: begin
                    if (scl_rise) begin
                        n.cnt = ACK_CLOCK_SEEN;
                    end else if (scl_fall && s.cnt == ACK_CLOCK_SEEN) begin
                        n.cnt = 4'h0;
                        if (s.rw) begin
                            n.fsm      = BUS_RD;
                            n.tx       = rd_data;
                            n.sda_oe   = ~rd_data[7];
                            n.byte_idx = 2'(s.byte_idx + 2'h1);
                        end else begin
                            n.fsm    = BUS_WR;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                BUS_RD: begin
                    if (scl_rise) begin
                        n.cnt = 4'(s.cnt + 4'h1);
                    end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                        n.fsm    = BUS_RD_ACK;
                        n.sda_oe = 1'b0;
                        n.cnt    = 4'h0;
                    end else if (scl_fall) begin
                        n.tx     = {s.tx[6:0], 1'b0};
                        n.sda_oe = ~s.tx[6];
                    end
                end
                BUS_RD_ACK: begin
                    if (scl_rise) begin
                        n.master_ack = ~sda_s;
                        n.cnt        = ACK_CLOCK_SEEN;
                    end else if (scl_fall && s.cnt == ACK_CLOCK_SEEN) begin
                        n.cnt = 4'h0;
                        if (s.master_ack) begin
                            n.fsm      = BUS_RD;
                            n.tx       = rd_data;
                            n.sda_oe   = ~rd_data[7];
                            n.byte_idx = (s.byte_idx == 2'h3) ? s.byte_idx : 2'(s.byte_idx + 2'h1);
                        end else begin
                            n.fsm = BUS_IDLE;
                        end
                    end
                end
                default: begin
                    n.fsm    = BUS_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s          <= '0;
            s.cmd      <= COMMAND_RESET;
            s.alert_en <= ALERT_ENABLE_RESET;
            s.thresh   <= ALERT_THRESHOLD_RESET;
            s.ctrl     <= HOT_SWAP_CONTROL_RESET;
            s.scl_q    <= 1'b1;
            s.sda_q    <= 1'b1;
            s.on_q     <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs; the line is only ever pulled low, never driven high
    assign sda_out                        = 1'b0;
    assign sda_oe                         = s.sda_oe;
    assign adc_req.voltage_continuous     = s.cmd[CMD_VOLTAGE_CONTINUOUS];
    assign adc_req.current_continuous     = s.cmd[CMD_CURRENT_CONTINUOUS];
    assign adc_req.voltage_start          = s.v_start;
    assign adc_req.current_start          = s.i_start;
    assign adc_req.voltage_divider_select = s.cmd[CMD_VOLTAGE_DIVIDER_SELECT];
    assign software_off                   = s.ctrl[CTRL_SOFTWARE_OFF];
    assign off_status                     = s.software_off_q | ~s.on_q;
    assign alert_out                      = s.adc_alert | s.hs_flag | s.off_alert;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_cmd_apply;
        cmd_wr |=> adc_req.voltage_divider_select == $past(s.rx[CMD_VOLTAGE_DIVIDER_SELECT])
               && adc_req.current_continuous == $past(s.rx[CMD_CURRENT_CONTINUOUS]) && s.cmd[CMD_UNUSED] == 1'b0;
    endproperty
    a_cmd_apply: assert property (p_cmd_apply) else $error("command fields not applied");

    property p_once_pulse;
        cmd_wr && s.rx[CMD_V_ONCE] |=> adc_req.voltage_start ##1 !adc_req.voltage_start;
    endproperty
    a_once_pulse: assert property (p_once_pulse) else $error("single start not one pulse");

    property p_read_nack;
        s.fsm == BUS_ADDR_ACK && s.rw |-> !s.v_pending && !s.i_pending;
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("read acked while pending");

    property p_cont_zero;
        cmd_wr && s.rx[CMD_VOLTAGE_CONTINUOUS] && !adc_res.voltage_done |=> s.v_code == 12'h000;
    endproperty
    a_cont_zero: assert property (p_cont_zero) else $error("stale voltage after command");

    property p_ext_select;
        wr_done && s.byte_idx == 2'h0 && s.rx[EXT_FLAG_BIT]
        |=> s.ext_write && s.ext_sel == $past(s.rx[1:0]) && $stable(s.cmd);
    endproperty
    a_ext_select: assert property (p_ext_select) else $error("extended write misdecoded");

    property p_clear;
        clr && !hot_swap_fault_event |=> !s.hs_flag ##1 !s.alert_en[EN_CLEAR] || $past(wr_done);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not act");

    property p_hs_set;
        hs_event |=> s.hs_flag && alert_out;
    endproperty
    a_hs_set: assert property (p_hs_set) else $error("fault flag lost");

    property p_reset_vals;
        $fell(reset) |-> s.alert_en == ALERT_ENABLE_RESET && s.thresh == ALERT_THRESHOLD_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_single_oc;
        adc_res.current_done && i_over && s.alert_en[EN_SINGLE_OC] |=> s.adc_alert;
    endproperty
    a_single_oc: assert property (p_single_oc) else $error("single overcurrent missed");

    property p_quad_early;
        !s.alert_en[EN_SINGLE_OC] && !s.adc_alert && adc_res.current_done
        && s.over_cnt != OC_PRIOR_RUN |=> !s.adc_alert;
    endproperty
    a_quad_early: assert property (p_quad_early) else $error("quad alert too early");

    property p_addr_match;
        s.fsm == BUS_ADDR_ACK |-> s.rx[7:1] == own_addr && s.sda_oe;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("acked wrong address");

    property p_cmd_hold;
        !cmd_wr |=> $stable(s.cmd);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed alone");

    c_quick: cover property (s.fsm == BUS_WR && s.byte_idx == 2'h0 && stop_cond);
    c_cmd:   cover property (cmd_wr);
    c_ext:   cover property (wr_done && s.byte_idx == 2'h1 && s.ext_write);
    c_read:  cover property (s.fsm == BUS_RD_ACK && scl_fall && !s.master_ack);

endmodule
`default_nettype wire

// ---- core/pmc_pkg.sv ----
// Shared constants and types for the power monitor command decoder
package pmc_pkg;

    // ****************************************************************
    // Bus addressing and framing
    // ****************************************************************
    localparam logic [2:0] ADDR_BASE       = 3'h4;   // Fixed upper address bits 100
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0] ACK_CLOCK_SEEN  = 4'h1;
    localparam int         EXT_FLAG_BIT    = 7;      // Set in first byte marks extended write

    // ****************************************************************
    // Extended register selects
    // ****************************************************************
    localparam logic [1:0] SEL_ALERT_ENABLE     = 2'h1;
    localparam logic [1:0] SEL_ALERT_THRESHOLD  = 2'h2;
    localparam logic [1:0] SEL_HOT_SWAP_CONTROL = 2'h3;

    // ****************************************************************
    // Command byte fields
    // ****************************************************************
    localparam int CMD_VOLTAGE_CONTINUOUS = 0;
    localparam int CMD_V_ONCE = 1;
    localparam int CMD_CURRENT_CONTINUOUS = 2;
    localparam int CMD_I_ONCE = 3;
    localparam int CMD_VOLTAGE_DIVIDER_SELECT = 4;
    localparam int CMD_UNUSED = 5;
    localparam int CMD_STATUS = 6;

    // ****************************************************************
    // Alert enable and control fields, reset values
    // ****************************************************************
    localparam int EN_SINGLE_OC = 0;
    localparam int EN_QUAD_OC   = 1;
    localparam int EN_HS_FAULT  = 2;
    localparam int EN_OFF       = 3;
    localparam int EN_CLEAR     = 4;
    localparam int CTRL_SOFTWARE_OFF   = 0;
    localparam logic [7:0] ALERT_ENABLE_RESET     = 8'h04;
    localparam logic [7:0] ALERT_ENABLE_MASK      = 8'h1f;
    localparam logic [7:0] ALERT_THRESHOLD_RESET  = 8'hff;
    localparam logic [7:0] HOT_SWAP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] HOT_SWAP_CONTROL_MASK  = 8'h01;
    localparam logic [6:0] COMMAND_RESET          = 7'h00;
    localparam logic [2:0] OC_PRIOR_RUN           = 3'h3;  // Earlier hits before a quad trip
    localparam logic [2:0] OC_STATUS_RUN          = 3'h3;  // Run shown in status bit 0

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK
    } pmc_bus_state_t;

    typedef struct packed {
        logic voltage_continuous;
        logic current_continuous;
        logic voltage_start;
        logic current_start;
        logic voltage_divider_select;
    } pmc_adc_req_t;

    typedef struct packed {
        logic        voltage_done;
        logic        current_done;
        logic [11:0] voltage_code;
        logic [11:0] current_code;
    } pmc_adc_res_t;

    typedef struct packed {
        pmc_bus_state_t fsm;
        logic [3:0]     cnt;
        logic [7:0]     rx;
        logic [7:0]     tx;
        logic [1:0]     byte_idx;
        logic           rw;
        logic           ext_write;
        logic [1:0]     ext_sel;
        logic           master_ack;
        logic           sda_oe;
        logic [6:0]     cmd;
        logic           v_pending;
        logic           i_pending;
        logic           v_start;
        logic           i_start;
        logic [11:0]    v_code;
        logic [11:0]    i_code;
        logic [7:0]     alert_en;
        logic [7:0]     thresh;
        logic [7:0]     ctrl;
        logic [2:0]     over_cnt;
        logic           adc_alert;
        logic           hs_flag;
        logic           off_alert;
        logic           scl_q;
        logic           sda_q;
        logic           on_q;
        logic           software_off_q;
    } pmc_state_t;

endpackage

// ---- core/pmc_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pmc_sync #(
    parameter int               W    = 1,
    parameter logic [W-1:0]     INIT = '0
) (
    input  wire logic           ref_clk,
    input  wire logic           reset,
    input  wire logic [W-1:0]   din,
    output logic [W-1:0]        dout
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] hold_reg;

    // ****************************************************************
    // Stage one feeds only stage two, to keep metastability contained
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= INIT;
            hold_reg <= INIT;
        end else begin
            meta_reg <= din;
            hold_reg <= meta_reg;
        end
    end

    assign dout = hold_reg;

endmodule
`default_nettype wire

// ---- sim/pmc_bus_master.sv ----
// Serial bus master model driving clock and data toward the decoder
`timescale 1ns/1ps
`default_nettype none
module pmc_bus_master (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Data moves only while the clock is low; the line is read late in the high phase
    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        tk(3);
        sda_drv <= b;
        tk(3);
        scl <= 1'b1;
        tk(5);
        #1 s = sda;
        tk(1);
    endtask
    // Start from an idle bus only, with the clock high on entry; data is set high before the clock is
    task automatic start();
        sda_drv <= 1'b1;
        tk(3);
        scl <= 1'b1;
        tk(6);
        sda_drv <= 1'b0;
        tk(6);
    endtask
    task automatic stop();
        scl <= 1'b0;
        tk(3);
        sda_drv <= 1'b0;
        tk(3);
        scl <= 1'b1;
        tk(6);
        sda_drv <= 1'b1;
        tk(6);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // Released data line is pulled up, so a nack is simply letting go
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// ---- sim/power_monitor_i2c_command_decoder_tb.sv ----
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module power_monitor_i2c_command_decoder_tb;
    import pmc_pkg::*;
    logic ref_clk, reset, on_pin, scl, sda_drv, sda_oe, sda_out, sw_off, off_st, alert, ack;
    logic hs_oc, hs_ev;
    logic [3:0] apins;
    pmc_adc_res_t adc_res;
    pmc_adc_req_t adc_req;
    int error_cnt = 0, samples_checked = 0;
    logic [7:0] rb [3];
    localparam logic [6:0] DEV = {ADDR_BASE, 4'h9};
    // Open-drain wire: the device only ever pulls low
    wire logic sda = sda_oe ? sda_out : sda_drv;
    pmc_bus_master m_u (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    pmc_cmd_decoder dut_u (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_pin_high(apins[3:2]),
        .address_pin_low(apins[1:0]), .on_pin(on_pin), .hot_swap_overcurrent(hs_oc),
        .hot_swap_fault_event(hs_ev),
        .adc_res(adc_res), .adc_req(adc_req), .software_off(sw_off), .off_status(off_st),
        .alert_out(alert));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Single-bit results: acknowledges and output levels
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t bit got %b want %b", $time, got, exp);
        end
    endtask
    // Write transfer: address then b0, and b1 only when n > 1; every byte must be acknowledged
    task automatic wr(input int n, input logic [7:0] b0, input logic [7:0] b1);
        m_u.start();
        m_u.wbyte({DEV, 1'b0}, ack);
        chk1(ack, 1'b1);
        m_u.wbyte(b0, ack);
        chk1(ack, 1'b1);
        if (n > 1) m_u.wbyte(b1, ack);
        if (n > 1) chk1(ack, 1'b1);
        m_u.stop();
        m_u.tk(4);
    endtask
    // Read attempt; ok says whether the address should be acknowledged
    task automatic rd(input int n, input logic ok);
        m_u.start();
        m_u.wbyte({DEV, 1'b1}, ack);
        chk1(ack, ok);
        for (int i = 0; i < n && ok; i++) m_u.rbyte(i == n - 1, rb[i]);
        m_u.stop();
    endtask
    // Conversion results arrive as one-cycle done pulses
    task automatic conv(input logic [11:0] v, input logic [11:0] c);
        adc_res <= '{1'b1, 1'b1, v, c};
        @(posedge ref_clk);
        adc_res <= '{1'b0, 1'b0, v, c};
        m_u.tk(4);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end
    initial begin
        reset = 1'b1;
        on_pin = 1'b1;
        hs_oc = 1'b0;
        hs_ev = 1'b0;
        apins = DEV[3:0];
        adc_res = '0;
        m_u.tk(4);
        reset <= 1'b0;
        m_u.tk(4);
        hs_ev <= 1'b1;
        m_u.tk(1);
        hs_ev <= 1'b0;
        m_u.tk(2);
        chk1(alert, 1'b1);
        wr(2, 8'h81, 8'h10);
        chk1(alert, 1'b0);
        m_u.start();
        m_u.wbyte({ADDR_BASE, 4'h0, 1'b0}, ack);
        m_u.stop();
        chk1(ack, 1'b0);
        m_u.start();
        m_u.wbyte({DEV, 1'b0}, ack);
        m_u.stop();
        chk1(ack, 1'b1);
        wr(1, 8'h35, 8'h00);
        chk({3'h0, adc_req}, 8'h19);
        rd(3, 1'b1);
        chk(rb[0] | rb[1] | rb[2], 8'h00);
        conv(12'h123, 12'h456);
        rd(3, 1'b1);
        chk(rb[0], 8'h12);
        chk(rb[1], 8'h45);
        chk(rb[2], 8'h36);
        wr(1, 8'h08, 8'h00);
        rd(1, 1'b0);
        conv(12'h0, 12'habc);
        rd(2, 1'b1);
        chk(rb[0], 8'hab);
        chk(rb[1], 8'hc0);
        wr(1, 8'h02, 8'h00);
        rd(1, 1'b0);
        conv(12'h5a7, 12'h000);
        rd(2, 1'b1);
        chk(rb[0], 8'h5a);
        chk(rb[1], 8'h70);
        wr(2, 8'h82, 8'h80);
        wr(2, 8'h81, 8'h01);
        conv(12'h0, 12'h80f);
        chk1(alert, 1'b0);
        conv(12'h0, 12'h810);
        chk1(alert, 1'b1);
        wr(2, 8'h81, 8'h11);
        chk1(alert, 1'b0);
        wr(2, 8'h81, 8'h08);
        wr(2, 8'h83, 8'h01);
        chk1(sw_off, 1'b1);
        chk1(off_st, 1'b1);
        chk1(alert, 1'b1);
        hs_oc <= 1'b1;
        wr(1, 8'h40, 8'h00);
        rd(1, 1'b1);
        chk(rb[0], 8'h34);
        final_report();
    end
endmodule
`default_nettype wire
